// ===== src/rpx_pixel.sv
// pixel receiver, forwarder and pwm driver
`default_nettype none
module rpx_pixel (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RESETN,
   input  wire logic CLK_EN,
   // serial data
   input  wire logic DATA_IN,
   input  wire logic BACKUP_DATA_IN,
   output logic      DATA_OUT,
   // emitters
   output logic      PWM_GREEN,
   output logic      PWM_RED,
   output logic      PWM_BLUE
);
   // input synchronisers
   logic [1:0] din_sync_q;
   logic [1:0] bin_sync_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         din_sync_q <= 2'h0;
         bin_sync_q <= 2'h0;
      end else if (CLK_EN) begin
         din_sync_q <= {din_sync_q[0], DATA_IN};
         bin_sync_q <= {bin_sync_q[0], BACKUP_DATA_IN};
      end
   end

   // either line carries the stream; a dead upstream pixel holds its output low
   logic line;
   assign line = din_sync_q[1] | bin_sync_q[1];

   // symbol receiver
   rpx_pkg::rpx_rx_type        state_q;
   logic [rpx_pkg::CNT_W-1:0]  cnt_q;
   logic [4:0]                 nbits_q;
   logic [23:0]                shift_q;
   logic                       sym_valid;
   logic                       sym_bit;
   logic                       reset_code;
   logic                       in_frame_q;

   assign sym_valid  = (state_q == rpx_pkg::RX_HIGH) && !line;
   assign sym_bit    = cnt_q >= rpx_pkg::CNT_W'(rpx_pkg::BIT_SPLIT_CYC);
   assign reset_code = (state_q == rpx_pkg::RX_LOW) && !line
                       && cnt_q == rpx_pkg::CNT_W'(rpx_pkg::RESET_LOW_CYC);

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= rpx_pkg::RX_IDLE;
         cnt_q   <= '0;
      end else if (CLK_EN) begin
         case (state_q)
            rpx_pkg::RX_IDLE: begin
               cnt_q <= '0;
               if (line) begin
                  state_q <= rpx_pkg::RX_HIGH;
                  cnt_q   <= rpx_pkg::CNT_W'(1);
               end
            end
            rpx_pkg::RX_HIGH: begin
               if (line) begin
                  if (cnt_q != '1) cnt_q <= cnt_q + rpx_pkg::CNT_W'(1);
               end else begin
                  state_q <= rpx_pkg::RX_LOW;
                  cnt_q   <= rpx_pkg::CNT_W'(1);
               end
            end
            rpx_pkg::RX_LOW: begin
               if (line) begin
                  state_q <= rpx_pkg::RX_HIGH;
                  cnt_q   <= rpx_pkg::CNT_W'(1);
               end else if (reset_code) begin
                  state_q <= rpx_pkg::RX_IDLE;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + rpx_pkg::CNT_W'(1);
               end
            end
            default: begin
               state_q <= rpx_pkg::RX_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   // word capture: first 24 bits stay here
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         nbits_q    <= '0;
         shift_q    <= rpx_pkg::COLOUR_RST;
         in_frame_q <= 1'b0;
      end else if (CLK_EN) begin
         if (reset_code) begin
            nbits_q    <= '0;
            in_frame_q <= 1'b0;
         end else if (sym_valid) begin
            in_frame_q <= 1'b1;
            if (nbits_q != 5'(rpx_pkg::WORD_BITS)) begin
               shift_q <= {shift_q[22:0], sym_bit};
               nbits_q <= nbits_q + 5'h01;
            end
         end
      end
   end

   // latch into pwm only at the reset code so the whole chain changes together
   rpx_pkg::rpx_colour_type duty_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         duty_q <= rpx_pkg::COLOUR_RST;
      end else if (CLK_EN && reset_code && nbits_q == 5'(rpx_pkg::WORD_BITS)) begin
         duty_q <= shift_q;
      end
   end

   // two-entry buffer of bits to forward; the regenerator is the drain
   logic [1:0] fifo_data_q;
   logic [1:0] fifo_cnt_q;
   logic       fifo_wr_ptr_q;
   logic       fifo_rd_ptr_q;
   logic       push_valid;
   logic       push_ready;
   logic       pop_valid;
   logic       pop_ready;
   assign push_valid = sym_valid && nbits_q == 5'(rpx_pkg::WORD_BITS);
   assign push_ready = fifo_cnt_q != 2'h2;
   assign pop_valid  = fifo_cnt_q != 2'h0;

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         fifo_data_q   <= 2'h0;
         fifo_cnt_q    <= 2'h0;
         fifo_wr_ptr_q <= 1'b0;
         fifo_rd_ptr_q <= 1'b0;
      end else if (CLK_EN) begin
         if (push_valid && push_ready) begin
            fifo_data_q[fifo_wr_ptr_q] <= sym_bit;
            fifo_wr_ptr_q              <= ~fifo_wr_ptr_q;
         end
         if (pop_valid && pop_ready) fifo_rd_ptr_q <= ~fifo_rd_ptr_q;
         fifo_cnt_q <= fifo_cnt_q + 2'(push_valid && push_ready)
                       - 2'(pop_valid && pop_ready);
      end
   end

   // regenerate clean symbols at the nominal timing
   logic [7:0] tx_cnt_q;
   logic       tx_bit_q;
   logic       tx_busy_q;
   assign pop_ready = !tx_busy_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_cnt_q  <= 8'h00;
         tx_bit_q  <= 1'b0;
         tx_busy_q <= 1'b0;
         DATA_OUT  <= 1'b0;
      end else if (CLK_EN) begin
         if (!tx_busy_q) begin
            DATA_OUT <= 1'b0;
            if (pop_valid) begin
               tx_busy_q <= 1'b1;
               tx_bit_q  <= fifo_data_q[fifo_rd_ptr_q];
               tx_cnt_q  <= 8'h00;
               DATA_OUT  <= 1'b1;
            end
         end else begin
            tx_cnt_q <= tx_cnt_q + 8'h01;
            DATA_OUT <= tx_bit_q ? (tx_cnt_q < 8'(rpx_pkg::ONE_HIGH_CYC - 1))
                                 : (tx_cnt_q < 8'(rpx_pkg::ZERO_HIGH_CYC - 1));
            if (tx_cnt_q == 8'(rpx_pkg::SYM_CYC - 2)) tx_busy_q <= 1'b0;
         end
      end
   end

   // pwm: 256 steps, period near 1.2 kHz
   logic [8:0] pre_q;
   logic [7:0] phase_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pre_q   <= 9'h000;
         phase_q <= 8'h00;
      end else if (CLK_EN) begin
         if (pre_q == 9'(rpx_pkg::PWM_STEP_CYC - 1)) begin
            pre_q   <= 9'h000;
            phase_q <= phase_q + 8'h01;
         end else begin
            pre_q <= pre_q + 9'h001;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         PWM_GREEN <= 1'b0;
         PWM_RED   <= 1'b0;
         PWM_BLUE  <= 1'b0;
      end else if (CLK_EN) begin
         PWM_GREEN <= phase_q < duty_q.green;
         PWM_RED   <= phase_q < duty_q.red;
         PWM_BLUE  <= phase_q < duty_q.blue;
      end
   end

   // pulse width and rise spacing of the regenerated stream, watched by the checks below
   logic [7:0] out_hi_q;
   logic [7:0] out_gap_q;
   logic       out_prev_q;
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         out_hi_q   <= 8'h00;
         out_gap_q  <= 8'hff;
         out_prev_q <= 1'b0;
      end else if (CLK_EN) begin
         out_prev_q <= DATA_OUT;
         if (!DATA_OUT) out_hi_q <= 8'h00;
         else if (out_hi_q != 8'hff) out_hi_q <= out_hi_q + 8'h01;
         if (DATA_OUT && !out_prev_q) out_gap_q <= 8'h01;
         else if (out_gap_q != 8'hff) out_gap_q <= out_gap_q + 8'h01;
      end
   end

   // checks
   a_reset_latch: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && reset_code && nbits_q == 5'(rpx_pkg::WORD_BITS)) |=> duty_q == $past(shift_q))
      else $error("duty not loaded at reset code");
   a_duty_hold: assert property (@(posedge CLK) disable iff (!RESETN)
      !(CLK_EN && reset_code) |=> $stable(duty_q))
      else $error("duty changed outside reset code");
   a_word_limit: assert property (@(posedge CLK) disable iff (!RESETN)
      nbits_q <= 5'(rpx_pkg::WORD_BITS))
      else $error("bit count beyond word");
   a_fwd_only_after: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && sym_valid && nbits_q != 5'(rpx_pkg::WORD_BITS))
      |=> fifo_cnt_q <= $past(fifo_cnt_q))
      else $error("kept bit was forwarded");
   a_shift_bit: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && sym_valid && nbits_q < 5'(rpx_pkg::WORD_BITS))
      |=> shift_q[0] == $past(sym_bit))
      else $error("bit not shifted in at lsb");
   a_reset_clears: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && reset_code) |=> nbits_q == 5'h00 && state_q == rpx_pkg::RX_IDLE)
      else $error("reset code did not end frame");
   a_fifo_bound: assert property (@(posedge CLK) disable iff (!RESETN)
      fifo_cnt_q <= 2'h2)
      else $error("buffer overflow");
   a_tx_high_one: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && tx_busy_q && tx_bit_q && tx_cnt_q == 8'h46) |=> !DATA_OUT)
      else $error("one high too long");
   a_pwm_green: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && duty_q.green == 8'h00) |=> !PWM_GREEN)
      else $error("green lit at zero duty");

   // receiver and decode checks
   a_zero_decode: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && sym_valid && cnt_q <= rpx_pkg::CNT_W'(rpx_pkg::ZERO_HIGH_MAX_NS
       * rpx_pkg::CLK_MHZ / 1000)) |-> !sym_bit)
      else $error("short high not decoded as zero");
   a_one_decode: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && sym_valid && cnt_q >= rpx_pkg::CNT_W'(rpx_pkg::ONE_HIGH_MIN_NS
       * rpx_pkg::CLK_MHZ / 1000)) |-> sym_bit)
      else $error("long high not decoded as one");
   a_reset_threshold: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && state_q == rpx_pkg::RX_LOW
       && cnt_q < rpx_pkg::CNT_W'(rpx_pkg::RESET_LOW_CYC)) |=> state_q != rpx_pkg::RX_IDLE)
      else $error("frame ended before reset low time");
   a_backup_start: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && state_q == rpx_pkg::RX_IDLE && bin_sync_q[1])
      |=> state_q == rpx_pkg::RX_HIGH)
      else $error("backup line did not start a symbol");
   a_duty_short: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && reset_code && nbits_q != 5'(rpx_pkg::WORD_BITS)) |=> $stable(duty_q))
      else $error("short frame changed duty");

   // forwarding, pwm and enable checks
   a_fwd_width: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && !DATA_OUT && out_hi_q != 8'h00)
      |-> (out_hi_q == 8'(rpx_pkg::ONE_HIGH_CYC) || out_hi_q == 8'(rpx_pkg::ZERO_HIGH_CYC)))
      else $error("regenerated high width wrong");
   a_regen_gap: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && DATA_OUT && !out_prev_q)
      |-> out_gap_q >= 8'(rpx_pkg::SYM_CYC))
      else $error("regenerated symbols too close");
   a_pwm_red: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && duty_q.red == 8'h00) |=> !PWM_RED)
      else $error("red lit at zero duty");
   a_pwm_blue: assert property (@(posedge CLK) disable iff (!RESETN)
      (CLK_EN && duty_q.blue == 8'h00) |=> !PWM_BLUE)
      else $error("blue lit at zero duty");
   a_enable_freeze: assert property (@(posedge CLK) disable iff (!RESETN)
      !CLK_EN |=> $stable(state_q) && $stable(cnt_q) && $stable(duty_q) && $stable(phase_q)
                  && $stable(DATA_OUT) && $stable(PWM_GREEN) && $stable(nbits_q))
      else $error("state moved while clock enable low");

   // main scenarios
   c_frame_end: cover property (@(posedge CLK) disable iff (!RESETN)
      reset_code && nbits_q == 5'(rpx_pkg::WORD_BITS));
   c_forward: cover property (@(posedge CLK) disable iff (!RESETN)
      push_valid && push_ready);
   c_buffer_full: cover property (@(posedge CLK) disable iff (!RESETN)
      fifo_cnt_q == 2'h2);
   c_short_frame: cover property (@(posedge CLK) disable iff (!RESETN)
      reset_code && in_frame_q && nbits_q != 5'(rpx_pkg::WORD_BITS));
   c_backup_start: cover property (@(posedge CLK) disable iff (!RESETN)
      state_q == rpx_pkg::RX_IDLE && bin_sync_q[1] && !din_sync_q[1]);
endmodule : rpx_pixel
`default_nettype wire

// ===== src/rpx_pkg.sv
// constants and carrier types for the rgb pixel chain receiver
`default_nettype none
package rpx_pkg;
   localparam int CLK_MHZ = 100;
   // times in ns, dimming rate in Hz
   localparam int ZERO_HIGH_TIME_NS  = 320;
   localparam int ONE_HIGH_TIME_NS   = 640;
   localparam int ZERO_HIGH_MAX_NS   = 400;
   localparam int ONE_HIGH_MIN_NS    = 620;
   localparam int RESET_LOW_NS       = 80000;
   localparam int DIMMING_RATE_HZ    = 1200;
   // threshold sits midway between the zero max and the one min
   localparam int BIT_SPLIT_CYC  = (ZERO_HIGH_MAX_NS + ONE_HIGH_MIN_NS) * CLK_MHZ / 2000;
   localparam int ZERO_HIGH_CYC  = ZERO_HIGH_TIME_NS * CLK_MHZ / 1000;
   localparam int ONE_HIGH_CYC   = ONE_HIGH_TIME_NS * CLK_MHZ / 1000;
   localparam int RESET_LOW_CYC  = (RESET_LOW_NS * CLK_MHZ + 999) / 1000 + 1;
   localparam int PWM_STEP_CYC   = (CLK_MHZ * 1000000) / (DIMMING_RATE_HZ * 256);
   localparam int SYM_CYC        = 125;
   localparam int WORD_BITS      = 24;
   localparam int CNT_W          = 14;
   localparam logic [23:0] COLOUR_RST = 24'h000000;

   typedef struct packed {
      logic [7:0] green;
      logic [7:0] red;
      logic [7:0] blue;
   } rpx_colour_type;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_HIGH = 2'b01,
      RX_LOW  = 2'b11
   } rpx_rx_type;
endpackage : rpx_pkg
`default_nettype wire

// ===== tb/rpx_sender.sv
// upstream sender model driving one serial line
`default_nettype none
module rpx_sender (
   // clock
   input  wire logic CLK,
   // serial line
   output logic      LINE
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SYM_CYC = 125;
   localparam int RST_CYC = 8100;
   initial LINE = 1'b0;
   // high part sets the bit, low part fills up the period
   task automatic send_bit(input logic b);
      int hi;
      hi = b ? rpx_pkg::ONE_HIGH_CYC : rpx_pkg::ZERO_HIGH_CYC;
      @(posedge CLK) LINE <= 1'b1;
      repeat (hi) @(posedge CLK);
      LINE <= 1'b0;
      repeat (SYM_CYC - hi - 1) @(posedge CLK);
   endtask : send_bit
   task automatic send_word(input logic [31:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) send_bit(w[i]);
   endtask : send_word
   task automatic send_reset();
      @(posedge CLK) LINE <= 1'b0;
      repeat (RST_CYC) @(posedge CLK);
   endtask : send_reset
endmodule : rpx_sender
`default_nettype wire

// ===== tb/test_rpx_pixel.sv
// self-checking bench for the pixel receiver
`default_nettype none
module test_rpx_pixel;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK;
   logic RESETN;
   logic CLK_EN;
   logic DATA_IN;
   logic BACKUP_DATA_IN;
   logic DATA_OUT;
   logic PWM_GREEN;
   logic PWM_RED;
   logic PWM_BLUE;
   int   n_fail;
   int   checks_done;
   int   fwd_seen[$];
   int   exp_q[$];
   int   hi_cnt;

   rpx_pixel dut (.CLK(CLK), .RESETN(RESETN), .CLK_EN(CLK_EN), .DATA_IN(DATA_IN),
      .BACKUP_DATA_IN(BACKUP_DATA_IN), .DATA_OUT(DATA_OUT), .PWM_GREEN(PWM_GREEN),
      .PWM_RED(PWM_RED), .PWM_BLUE(PWM_BLUE));
   rpx_sender snd (.CLK(CLK), .LINE(DATA_IN));
   rpx_sender bak (.CLK(CLK), .LINE(BACKUP_DATA_IN));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   // width of each regenerated high pulse, sampled away from the edge
   always @(negedge CLK) begin
      if (DATA_OUT === 1'b1) hi_cnt++;
      else if (hi_cnt > 0) begin
         fwd_seen.push_back(hi_cnt);
         hi_cnt = 0;
      end
   end

   initial begin
      repeat (100000) @(posedge CLK);
      n_fail++;
      give_verdict();
   end

   initial begin
      logic [31:0] seed;
      logic [23:0] col;
      logic [7:0]  extra;
      logic [3:0]  held;
      int          g;
      int          r;
      int          b;
      RESETN = 1'b0;
      CLK_EN = 1'b1;
      hi_cnt = 0;
      seed = 32'h78388fe6;
      repeat (12) @(posedge CLK);
      check(32'({DATA_OUT, PWM_GREEN, PWM_RED, PWM_BLUE}), 32'h0);
      RESETN <= 1'b1;
      // full word plus eight bits for the next pixel
      seed = lfsr(seed);
      extra = seed[7:0];
      seed = lfsr(seed);
      for (int i = 7; i >= 0; i--) exp_q.push_back(extra[i] ? 64 : 32);
      snd.send_word({seed[23:0], extra}, 32);
      snd.send_reset();
      check(fwd_seen.size(), exp_q.size());
      foreach (exp_q[i]) check(fwd_seen[i], exp_q[i]);
      // enable low freezes every output between frames
      @(posedge CLK) CLK_EN <= 1'b0;
      @(negedge CLK) held = {DATA_OUT, PWM_GREEN, PWM_RED, PWM_BLUE};
      repeat (400) @(posedge CLK);
      check(32'({DATA_OUT, PWM_GREEN, PWM_RED, PWM_BLUE}), 32'(held));
      CLK_EN <= 1'b1;
      // small duties keep the pwm measurement short; word on backup line
      fwd_seen.delete();
      seed = lfsr(seed);
      col = {5'h00, seed[2:0] | 3'h1, 5'h00, seed[5:3], 5'h00, seed[8:6]};
      bak.send_word({8'h00, col}, 24);
      bak.send_reset();
      check(fwd_seen.size(), 0);
      // short frame must leave the duty alone
      snd.send_word(lfsr(seed), 10);
      snd.send_reset();
      check(fwd_seen.size(), 0);
      // start on a rising edge so the whole pulse is counted
      for (int i = 0; i < 90000 && PWM_GREEN !== 1'b0; i++) @(negedge CLK);
      for (int i = 0; i < 90000 && PWM_GREEN !== 1'b1; i++) @(negedge CLK);
      g = 0;
      r = 0;
      b = 0;
      for (int i = 0; i < 3000; i++) begin
         g += (PWM_GREEN === 1'b1);
         r += (PWM_RED === 1'b1);
         b += (PWM_BLUE === 1'b1);
         @(negedge CLK);
      end
      check(g, col[23:16] * rpx_pkg::PWM_STEP_CYC);
      check(r, col[15:8] * rpx_pkg::PWM_STEP_CYC);
      check(b, col[7:0] * rpx_pkg::PWM_STEP_CYC);
      give_verdict();
   end
endmodule : test_rpx_pixel
`default_nettype wire
